// ---- design/eei_if.sv ----
// two-wire bus with pull-ups resolved from the drivers' enables
interface eei_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport slave (
    input scl,
    input sda,
    output s_sda_o,
    output s_sda_oe
  );
  modport master (
    input scl,
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );
endinterface

// ---- design/eei_map.svh ----
// constants for the two-wire serial memory link
`ifndef EEI_MAP_SVH
`define EEI_MAP_SVH
`define EEI_CLK_MHZ 250
`define EEI_PROG_TIME_MS 5
`define EEI_PROG_CYC (`EEI_PROG_TIME_MS * 1000 * `EEI_CLK_MHZ)
`define EEI_PU_TIME_MS 1
`define EEI_PU_CYC (`EEI_PU_TIME_MS * 1000 * `EEI_CLK_MHZ)
`define EEI_FSCL_KHZ 400
`define EEI_HALF_CYC ((`EEI_CLK_MHZ * 1000 + 2 * `EEI_FSCL_KHZ - 1) / (2 * `EEI_FSCL_KHZ))
`define EEI_TBUF_NS 1300
`define EEI_TBUF_CYC ((`EEI_TBUF_NS * `EEI_CLK_MHZ + 999) / 1000)
// device type code: arbitrary value
`define EEI_TYPE_CODE 4'h5
`define EEI_ADDR_W 14
`define EEI_ACK_CNT 4'h8
`define EEI_END_CNT 4'h9
`define EEI_IN_SDA 0
`define EEI_IN_SCL 1
`define EEI_IN_STRAP_LO 2
`define EEI_IN_STRAP_HI 4
`define EEI_IN_WP 5
`define EEI_IN_PWR 6
`define EEI_IN_W 7
`endif

// ---- design/eei_master.sv ----
// bus master end: clock divider, framing and single-byte transfers
`include "eei_map.svh"
module eei_master #(
  parameter logic [3:0] TYPE_CODE = `EEI_TYPE_CODE,
  parameter int HALF_CYCLES = `EEI_HALF_CYC,
  parameter int TBUF_CYCLES = `EEI_TBUF_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial bus
  eei_if.master bus,
  // command
  input wire logic cmd_valid,
  input wire eei_pkg::eei_cmd_type cmd_kind,
  input wire logic [2:0] cmd_strap,
  input wire logic [13:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // answer
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  import eei_pkg::*;

  eei_mstate_type st_r;
  logic [15:0] tmr_r;
  logic ph_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  eei_cmd_type kind_r;
  logic [2:0] strap_r;
  logic [13:0] addr_r;
  logic [7:0] data_r;
  logic [7:0] sh_r;
  logic [7:0] rxd_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic ready_r;
  logic done_r;
  logic nack_r;
  logic [7:0] rd_r;
  logic sda1_r;
  logic sda2_r;
  logic tmr_end;
  logic tmr_mid;
  logic rx_byte;
  logic last_byte;
  logic [7:0] next_byte;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sda1_r <= 1'b1;
      sda2_r <= 1'b1;
    end
    else
    begin
      sda1_r <= bus.sda;
      sda2_r <= sda1_r;
    end
  end

  assign tmr_end = (tmr_r == 16'(HALF_CYCLES - 1));
  assign tmr_mid = (tmr_r == 16'(HALF_CYCLES / 2));
  assign rx_byte = (kind_r == CMD_READ) && (byte_r != 2'd0);
  assign last_byte = (kind_r == CMD_READ) ? (byte_r == 2'd1)
    : (byte_r == 2'd3);

  always_comb
  begin
    case (byte_r)
      2'd0:
        next_byte = {TYPE_CODE, strap_r, 1'b0};
      2'd1:
        next_byte = addr_r[7:0];
      default:
        next_byte = data_r;
    endcase
  end

  // the master alone makes clock, start and stop; data moves
  // mid-way through the low half so it never races a clock edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_r <= M_IDLE;
      tmr_r <= '0;
      ph_r <= 1'b0;
      bit_r <= '0;
      byte_r <= '0;
      kind_r <= CMD_WRITE;
      strap_r <= '0;
      addr_r <= '0;
      data_r <= '0;
      sh_r <= '0;
      rxd_r <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      rd_r <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      tmr_r <= tmr_end ? '0 : tmr_r + 16'd1;
      case (st_r)
        M_IDLE:
        begin
          tmr_r <= '0;
          if (cmd_valid)
          begin
            st_r <= M_START;
            ready_r <= 1'b0;
            nack_r <= 1'b0;
            kind_r <= cmd_kind;
            strap_r <= cmd_strap;
            addr_r <= cmd_addr;
            data_r <= cmd_data;
            sh_r <= {TYPE_CODE, cmd_strap, cmd_kind};
            byte_r <= '0;
            bit_r <= '0;
            ph_r <= 1'b0;
          end
        end
        M_START:
        begin
          if (tmr_end)
          begin
            ph_r <= ~ph_r;
            if (!ph_r)
              sda_oe_r <= 1'b1;
            else
            begin
              scl_oe_r <= 1'b1;
              st_r <= M_BIT;
            end
          end
        end
        M_BIT:
        begin
          if (!ph_r && tmr_mid)
            sda_oe_r <= (bit_r != `EEI_ACK_CNT) && !rx_byte
              && !sh_r[7];
          else if (!ph_r && tmr_end)
          begin
            scl_oe_r <= 1'b0;
            ph_r <= 1'b1;
          end
          else if (ph_r && tmr_end)
          begin
            scl_oe_r <= 1'b1;
            ph_r <= 1'b0;
            if (bit_r != `EEI_ACK_CNT)
            begin
              bit_r <= bit_r + 4'h1;
              sh_r <= {sh_r[6:0], 1'b0};
              rxd_r <= {rxd_r[6:0], sda2_r};
            end
            else
            begin
              bit_r <= '0;
              if (!rx_byte && sda2_r)
              begin
                nack_r <= 1'b1;
                st_r <= M_STOP;
              end
              else if (last_byte)
              begin
                rd_r <= rxd_r;
                st_r <= M_STOP;
              end
              else
              begin
                byte_r <= byte_r + 2'd1;
                sh_r <= (byte_r == 2'd0) ? {2'b00, addr_r[13:8]}
                  : next_byte;
              end
            end
          end
        end
        M_STOP:
        begin
          if (!ph_r && tmr_mid)
            sda_oe_r <= 1'b1;
          else if (!ph_r && tmr_end)
          begin
            scl_oe_r <= 1'b0;
            ph_r <= 1'b1;
          end
          else if (ph_r && tmr_end)
          begin
            sda_oe_r <= 1'b0;
            ph_r <= 1'b0;
            st_r <= M_FREE;
          end
        end
        M_FREE:
        begin
          if (tmr_r == 16'(TBUF_CYCLES - 1))
          begin
            st_r <= M_IDLE;
            ready_r <= 1'b1;
            done_r <= 1'b1;
          end
          else
            tmr_r <= tmr_r + 16'd1;
        end
        default:
          st_r <= M_IDLE;
      endcase
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_r;
  assign cmd_ready = ready_r;
  assign done = done_r;
  assign nack = nack_r;
  assign rd_data = rd_r;
endmodule

// ---- design/eei_pkg.sv ----
// types shared by both ends of the serial memory link
package eei_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b010,
    ST_ALO = 3'b011,
    ST_DATA = 3'b100,
    ST_READ = 3'b101,
    ST_SKIP = 3'b110
  } eei_state_type;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_STOP = 3'b011,
    M_FREE = 3'b100
  } eei_mstate_type;
  typedef enum logic {
    CMD_WRITE = 1'b0,
    CMD_READ = 1'b1
  } eei_cmd_type;
endpackage

// ---- design/eei_slave.sv ----
// serial memory slave end: framing, addressing, acknowledge, program cycle
`include "eei_map.svh"
module eei_slave #(
  parameter int ADDR_W = `EEI_ADDR_W,
  parameter logic [3:0] TYPE_CODE = `EEI_TYPE_CODE,
  parameter int PROG_CYCLES = `EEI_PROG_CYC,
  parameter int PU_CYCLES = `EEI_PU_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial bus
  eei_if.slave bus,
  // supply monitor, straps and protection
  input wire logic power_ok,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic write_protect,
  // status
  output logic ready,
  output logic busy
);
  import eei_pkg::*;

  logic [`EEI_IN_W-1:0] sync1_r;
  logic [`EEI_IN_W-1:0] sync2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic por_rst;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic act;
  logic ack_slot;
  logic end_slot;
  logic match;
  logic wp_block;
  logic [2:0] strap;
  eei_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] buf_r;
  logic [7:0] rd_byte;
  logic [ADDR_W-1:0] addr_r;
  logic rw_r;
  logic first_r;
  logic wp_lat_r;
  logic pend_r;
  logic sda_oe_r;
  logic ready_r;
  logic busy_r;
  logic [31:0] pu_cnt_r;
  logic [31:0] prog_cnt_r;
  logic prog_last;
  logic [7:0] mem [0:(1 << ADDR_W) - 1];

  // pins and the bus come from outside this clock
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {power_ok, write_protect, chip_select_strap_2,
        chip_select_strap_1, chip_select_strap_0, bus.scl, bus.sda};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[`EEI_IN_SCL];
      sda_d_r <= sync2_r[`EEI_IN_SDA];
    end
  end

  assign scl_s = sync2_r[`EEI_IN_SCL];
  assign sda_s = sync2_r[`EEI_IN_SDA];
  assign strap = sync2_r[`EEI_IN_STRAP_HI:`EEI_IN_STRAP_LO];
  assign por_rst = sys_rst | ~sync2_r[`EEI_IN_PWR];
  assign rise = scl_s & ~scl_d_r;
  assign fall = ~scl_s & scl_d_r;
  // data moving while the clock is high frames a command
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign act = (state_r != ST_IDLE) && (state_r != ST_SKIP);
  assign ack_slot = act && fall && (cnt_r == `EEI_ACK_CNT);
  assign end_slot = act && fall && (cnt_r == `EEI_END_CNT);
  assign match = (rx_r[7:4] == TYPE_CODE) && (rx_r[3:1] == strap)
    && ready_r && !busy_r;
  assign wp_block = wp_lat_r && first_r;
  assign rd_byte = mem[addr_r];
  assign prog_last = (prog_cnt_r == 32'(PROG_CYCLES - 1));

  // power-up delay before the first command is answered
  always_ff @(posedge clock)
  begin
    if (por_rst)
    begin
      pu_cnt_r <= '0;
      ready_r <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (pu_cnt_r == 32'(PU_CYCLES - 1))
        ready_r <= 1'b1;
      else
        pu_cnt_r <= pu_cnt_r + 32'd1;
    end
  end

  // byte framing and command sequence
  always_ff @(posedge clock)
  begin
    if (por_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else if (start_det)
    begin
      state_r <= ST_DEV;
      cnt_r <= '0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else if (act)
    begin
      if (rise && (cnt_r < `EEI_ACK_CNT))
        cnt_r <= cnt_r + 4'h1;
      else if (ack_slot)
      begin
        cnt_r <= `EEI_END_CNT;
        case (state_r)
          ST_DEV:
          begin
            if (!match)
              state_r <= ST_SKIP;
          end
          ST_DATA:
          begin
            if (wp_block)
              state_r <= ST_SKIP;
          end
          default:
          begin
          end
        endcase
      end
      else if (rise && (cnt_r == `EEI_END_CNT) && (state_r == ST_READ)
        && sda_s)
        state_r <= ST_SKIP;
      else if (end_slot)
      begin
        cnt_r <= '0;
        case (state_r)
          ST_DEV:
            state_r <= rw_r ? ST_READ : ST_AHI;
          ST_AHI:
            state_r <= ST_ALO;
          ST_ALO:
            state_r <= ST_DATA;
          default:
            state_r <= state_r;
        endcase
      end
    end
  end

  // receive shifter, address counter and write buffer
  always_ff @(posedge clock)
  begin
    if (por_rst)
    begin
      rx_r <= '0;
      tx_r <= '0;
      buf_r <= '0;
      addr_r <= '0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      wp_lat_r <= 1'b0;
      pend_r <= 1'b0;
    end
    else if (start_det)
      pend_r <= 1'b0;
    else if (act)
    begin
      if (rise && (cnt_r < `EEI_ACK_CNT) && (state_r != ST_READ))
        rx_r <= {rx_r[6:0], sda_s};
      if (ack_slot)
      begin
        case (state_r)
          ST_DEV:
            rw_r <= rx_r[0];
          ST_AHI:
            addr_r[ADDR_W-1:8] <= rx_r[ADDR_W-9:0];
          ST_ALO:
            addr_r[7:0] <= rx_r;
          ST_DATA:
          begin
            if (!wp_block)
            begin
              buf_r <= rx_r;
              pend_r <= 1'b1;
              first_r <= 1'b0;
            end
          end
          ST_READ:
            addr_r <= addr_r + 1'b1; // wraps at end of memory
          default:
          begin
          end
        endcase
      end
      if (end_slot && (state_r == ST_ALO))
      begin
        wp_lat_r <= sync2_r[`EEI_IN_WP];
        first_r <= 1'b1;
        pend_r <= 1'b0;
      end
      if (end_slot && ((state_r == ST_READ) || (state_r == ST_DEV)))
        tx_r <= rd_byte;
      else if (fall && (state_r == ST_READ) && (cnt_r != '0)
        && (cnt_r < `EEI_ACK_CNT))
        tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // open-drain data drive, changed only on clock falls
  always_ff @(posedge clock)
  begin
    if (por_rst || start_det || stop_det || !act)
      sda_oe_r <= 1'b0;
    else if (ack_slot)
    begin
      case (state_r)
        ST_DEV:
          sda_oe_r <= match;
        ST_AHI, ST_ALO:
          sda_oe_r <= 1'b1;
        ST_DATA:
          sda_oe_r <= !wp_block;
        default:
          sda_oe_r <= 1'b0;
      endcase
    end
    else if (end_slot)
    begin
      if ((state_r == ST_READ) || ((state_r == ST_DEV) && rw_r))
        sda_oe_r <= ~rd_byte[7];
      else
        sda_oe_r <= 1'b0;
    end
    else if (fall && (state_r == ST_READ) && (cnt_r != '0)
      && (cnt_r < `EEI_ACK_CNT))
      sda_oe_r <= ~tx_r[6];
  end

  // program cycle launched by stop after an accepted data byte
  always_ff @(posedge clock)
  begin
    if (por_rst)
    begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end
    else if (!busy_r && stop_det && pend_r && (state_r == ST_DATA))
    begin
      busy_r <= 1'b1;
      prog_cnt_r <= '0;
    end
    else if (busy_r)
    begin
      if (prog_last)
        busy_r <= 1'b0;
      else
        prog_cnt_r <= prog_cnt_r + 32'd1;
    end
  end

  // array has no reset: contents survive a supply dip
  always_ff @(posedge clock)
  begin
    if (busy_r && prog_last)
      mem[addr_r] <= buf_r;
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_r;
  assign ready = ready_r;
  assign busy = busy_r;
endmodule

// ---- dv/eei_assertions.sv ----
// concurrent checks on the two-wire link between master and slave ends
module eei_checker #(
  parameter int PROG_CYCLES = 50,
  parameter int TBUF_CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // resolved bus lines and slave drive enable
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  // slave supply and status
  input wire logic power_ok,
  input wire logic ready,
  input wire logic busy
);
  logic scl_q_r;
  logic sda_q_r;
  logic framed_r;
  logic [7:0] stop_age_r;
  logic [15:0] busy_cnt_r;
  logic start_seen;
  logic stop_seen;

  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // edges judged from one registered copy of the lines
  assign start_seen = scl && scl_q_r && sda_q_r && !sda;
  assign stop_seen = scl && scl_q_r && !sda_q_r && sda;

  always_ff @(posedge clock)
  begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      framed_r <= 1'b0;
    else if (start_seen)
      framed_r <= 1'b1;
    else if (stop_seen)
      framed_r <= 1'b0;
  end

  // saturates so the first start after reset counts as free
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stop_age_r <= 8'hff;
    else if (stop_seen)
      stop_age_r <= 8'h00;
    else if (stop_age_r != 8'hff)
      stop_age_r <= stop_age_r + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !busy)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;
  end

  sequence scl_rise_soon;
    ##[1:40] $rose(scl);
  endsequence

  sequence supply_low;
    !power_ok [*5];
  endsequence

  slave_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave data changed while clock high");
  ack_hold_a: assert property (
    $rose(s_sda_oe) |-> s_sda_oe throughout scl_rise_soon)
    else $error("slave drive not held to next clock rise");
  frame_only_a: assert property (s_sda_oe |-> framed_r)
    else $error("slave drove data outside a frame");
  prog_quiet_a: assert property (busy |-> !s_sda_oe)
    else $error("slave drove data during program cycle");
  prog_max_a: assert property (busy |-> busy_cnt_r <= PROG_CYCLES + 2)
    else $error("program cycle too long");
  prog_len_a: assert property (
    $fell(busy) && power_ok |-> $past(busy_cnt_r) >= PROG_CYCLES - 2)
    else $error("program cycle too short");
  prog_cause_a: assert property ($rose(busy) |-> stop_age_r <= 8)
    else $error("program cycle began without a stop");
  bus_free_a: assert property (
    start_seen |-> stop_age_r >= TBUF_CYCLES)
    else $error("start too soon after stop");
  ready_gate_a: assert property (!ready |-> !s_sda_oe)
    else $error("slave answered before ready");
  brownout_a: assert property (supply_low |-> !ready && !busy)
    else $error("slave not in reset with supply low");
endmodule

// ---- dv/eeprom_i2c_slave_byte_write_tb_top.sv ----
// self-checking bench: master and slave ends joined over the two-wire bus
module eeprom_i2c_slave_byte_write_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import eei_pkg::*;
  // program cycle long enough to poll inside it
  localparam int PROG = 1000;
  localparam int PU = 20;
  logic clock;
  logic sys_rst;
  logic power_ok;
  logic [2:0] slave_strap;
  logic write_protect;
  logic cmd_valid;
  eei_cmd_type cmd_kind;
  logic [2:0] cmd_strap;
  logic [13:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic done;
  logic nack;
  logic [7:0] rd_data;
  logic ready;
  logic busy;
  int n_mismatch = 0;
  int checks_done = 0;

  eei_if bus ();
  eei_slave #(.PROG_CYCLES(PROG), .PU_CYCLES(PU)) u_eei_slave (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .power_ok(power_ok),
    .chip_select_strap_0(slave_strap[0]),
    .chip_select_strap_1(slave_strap[1]),
    .chip_select_strap_2(slave_strap[2]),
    .write_protect(write_protect), .ready(ready), .busy(busy));
  eei_master #(.HALF_CYCLES(16), .TBUF_CYCLES(16)) u_eei_master (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_strap(cmd_strap), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .nack(nack),
    .rd_data(rd_data));
  eei_checker #(.PROG_CYCLES(PROG), .TBUF_CYCLES(16)) u_eei_checker (
    .clock(clock), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
    .s_sda_oe(bus.s_sda_oe), .power_ok(power_ok), .ready(ready),
    .busy(busy));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after an edge; the done cycle is the exit point
  task automatic run_cmd(input eei_cmd_type kind, input logic [2:0] strap,
    input logic [13:0] addr, input logic [7:0] data);
    int i;
    cmd_kind = kind;
    cmd_strap = strap;
    cmd_addr = addr;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    check(cmd_ready, 1'b0);
    for (i = 0; i < 3000 && done !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (done !== 1'b1)
    begin
      n_mismatch++;
      $display("Error at %0t: command never completed", $time);
    end
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && busy !== 1'b0; i++)
    begin
      @(posedge clock);
      #1;
    end
  endtask

  initial
  begin
    sys_rst = 1'b1;
    power_ok = 1'b1;
    slave_strap = 3'h5;
    write_protect = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_WRITE;
    cmd_strap = 3'h0;
    cmd_addr = 14'h0000;
    cmd_data = 8'h00;
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    check(ready, 1'b0);
    repeat (PU + 8) @(posedge clock);
    #1 check(ready, 1'b1);
    run_cmd(CMD_WRITE, 3'h5, 14'h2a5c, 8'h3c);
    check(nack, 1'b0);
    check(busy, 1'b1);
    run_cmd(CMD_READ, 3'h5, 14'h0000, 8'h00);
    check(nack, 1'b1);
    wait_idle();
    run_cmd(CMD_READ, 3'h5, 14'h0000, 8'h00);
    check(nack, 1'b0);
    check(rd_data, 8'h3c);
    run_cmd(CMD_WRITE, 3'h5, 14'h0100, 8'ha5);
    wait_idle();
    write_protect = 1'b1;
    run_cmd(CMD_WRITE, 3'h5, 14'h0100, 8'h77);
    check(nack, 1'b1);
    check(busy, 1'b0);
    write_protect = 1'b0;
    run_cmd(CMD_READ, 3'h5, 14'h0000, 8'h00);
    check(rd_data, 8'ha5);
    // every strap value, even ones written and odd ones read; only one device answers
    for (int k = 0; k < 8; k++)
    begin
      run_cmd(eei_cmd_type'(k[0]), k[2:0], 14'h0155, 8'h5a);
      check(nack, k != 5);
    end
    slave_strap = 3'h2;
    run_cmd(CMD_READ, 3'h5, 14'h0000, 8'h00);
    check(nack, 1'b1);
    run_cmd(CMD_READ, 3'h2, 14'h0000, 8'h00);
    check(nack, 1'b0);
    power_ok = 1'b0;
    repeat (10) @(posedge clock);
    #1 check(ready, 1'b0);
    power_ok = 1'b1;
    repeat (PU + 8) @(posedge clock);
    #1 check(ready, 1'b1);
    run_cmd(CMD_READ, 3'h2, 14'h0000, 8'h00);
    check(nack, 1'b0);
    tally_and_finish();
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    $display("Error at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule
